// File: core/src_debounce.sv
// Two-stage synchroniser plus stable-count debouncer for one input
`timescale 1ns/1ns
`default_nettype none
`include "src_defines.svh"
module src_debounce #(
    parameter logic [15:0] STABLE_CYCLES = `SRC_DEBOUNCE_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_raw,
    output logic o_level
);
    logic meta_ff, sync_ff, level_ff;
    logic [15:0] cnt_ff;
    logic nxt_level;
    logic [15:0] nxt_cnt;

    always_comb begin
        nxt_level = level_ff;
        nxt_cnt = cnt_ff;
        if (sync_ff == level_ff) begin
            nxt_cnt = 16'h0000;
        end else if (cnt_ff >= STABLE_CYCLES) begin
            nxt_level = sync_ff;
            nxt_cnt = 16'h0000;
        end else begin
            nxt_cnt = cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
            level_ff <= 1'b1;
            cnt_ff <= 16'h0000;
        end else begin
            meta_ff <= i_raw;
            sync_ff <= meta_ff;
            level_ff <= nxt_level;
            cnt_ff <= nxt_cnt;
        end
    end

    assign o_level = level_ff;
endmodule
`default_nettype wire

// File: core/src_defines.svh
// Constants for the serial clock/calendar core
`ifndef SRC_DEFINES_SVH
`define SRC_DEFINES_SVH
`define SRC_SLAVE_ADDR 7'h68
`define SRC_SPACE_BYTES 64
`define SRC_CLOCK_REGS 20
`define SRC_TIME_REGS 8
`define SRC_RAM_BYTES 44
`define SRC_LAST_TIME_ADDR 6'h07
`define SRC_A_HUND 6'h00
`define SRC_A_SEC 6'h01
`define SRC_A_MIN 6'h02
`define SRC_A_HOUR 6'h03
`define SRC_A_DAY 6'h04
`define SRC_A_DATE 6'h05
`define SRC_A_MONTH 6'h06
`define SRC_A_YEAR 6'h07
`define SRC_XTAL_HZ 32768
`define SRC_TICKS_PER_HUND 9'd328
`define SRC_DEBOUNCE_CYCLES 16'd1000
`define SRC_BIT_CENTURY 6
`endif

// File: core/src_pkg.sv
// Types for the serial clock/calendar core
package src_pkg;
    typedef enum logic [2:0] {
        SRC_IDLE = 3'b000,
        SRC_ADDR = 3'b001,
        SRC_ADDR_ACK = 3'b010,
        SRC_RX = 3'b011,
        SRC_RX_ACK = 3'b100,
        SRC_TX = 3'b101,
        SRC_TX_ACK = 3'b110,
        SRC_DROP = 3'b111
    } src_state_t;
endpackage

// File: core/src_rtc_core.sv
// Serial real-time clock core: calendar, two-wire slave, supervisor gates
// Summary of operation
// - A 64-byte space holds 8 time registers then user RAM at 08h-3Fh; reads below 3Ch return the time copy.
// - Every clock register holds one BCD digit per nibble, except hours, whose bit 6 holds the century.
// - The address register steps by one after every data byte written or read.
// - All timekeeping advances from the 32.768 kHz crystal clock.
// - Eight registers count time and date; the square wave runs free from the crystal counter.
// - Hundredths, seconds, minutes, 24-hour hours, day, date, month, year, century count.
// - Dates roll over at 28/29/30/31 days with leap February valid until 2100.
// - A power failure blocks the chip enable to the external SRAM.
// - Two auxiliary reset inputs are debounced and, with power-on reset, drive reset out.
// - Address and data pass over the two-wire bus; master clocks, both drive data.
// - The interrupt/test/output pin is open drain and never pulls low; its enable stays at zero.
// - Each access starts with a start condition and address D0h; only D0h and D1h (read) are answered.
// - The pointer increments on an acknowledge clock; a written word address sets it.
// - While the pointer is in 00h-07h the time-to-user copy freezes until stop or exit.
// - Out-of-tolerance supply aborts access, clears the pointer and ignores the bus.
`timescale 1ns/1ns
`default_nettype none
`include "src_defines.svh"
module src_rtc_core
    import src_pkg::*;
#(
    parameter logic [8:0] TICKS_PER_HUND = `SRC_TICKS_PER_HUND
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_xtal_clock,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_oe,
    output logic o_sda_out,
    input wire logic i_sram_enable_in_n,
    output logic o_gated_sram_enable_out_n,
    input wire logic i_powerfail_sense_in,
    output logic o_powerfail_warn_out_n,
    input wire logic i_vcc_fail,
    input wire logic i_aux_reset_in_a_n,
    input wire logic i_aux_reset_in_b_n,
    output logic o_reset_oe,
    output logic o_reset_out,
    output logic o_irq_test_out_pin_oe,
    output logic o_irq_test_out_pin_out,
    output logic o_square_wave_out
);
    // Crystal domain: time counter runs on the crystal clock, never on i_clock
    logic xrst_m_ff, xrst_ff;
    logic [8:0] xdiv_ff, nxt_xdiv;
    logic xtick_ff, nxt_xtick;
    logic [7:0] t_ff [0:`SRC_TIME_REGS-1];
    logic [7:0] nxt_t [0:`SRC_TIME_REGS-1];
    logic xwr_tgl_m_ff, xwr_tgl_s_ff, xwr_tgl_d_ff;
    logic [7:0] sq_cnt_ff, nxt_sq_cnt;
    logic sq_ff;
    logic [7:0] hr_inc;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    function automatic logic [7:0] month_len(input logic [7:0] mon, input logic [7:0] yr);
        logic leap;
        // BCD year divisible by four: even tens with 0/4/8, odd tens with 2/6
        leap = yr[4] ? (yr[1:0] == 2'b10) : (yr[1:0] == 2'b00);
        case (mon)
            8'h02: month_len = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
            default: month_len = 8'h31;
        endcase
    endfunction

    assign hr_inc = bcd_inc({2'b00, t_ff[3][5:0]});

    // Write request crossing from the system domain (bus writes to clock registers)
    logic wr_tgl_ff, nxt_wr_tgl;
    logic [2:0] wr_idx_ff, nxt_wr_idx;
    logic [7:0] wr_dat_ff, nxt_wr_dat;

    always_comb begin
        logic cy;
        cy = 1'b0;
        nxt_xdiv = xdiv_ff + 9'h001;
        nxt_xtick = 1'b0;
        if (xdiv_ff >= TICKS_PER_HUND - 9'h001) begin
            nxt_xdiv = 9'h000;
            nxt_xtick = 1'b1;
        end
        for (int i = 0; i < `SRC_TIME_REGS; i++) begin
            nxt_t[i] = t_ff[i];
        end
        nxt_sq_cnt = sq_cnt_ff + 8'h01;
        if (xtick_ff) begin
            cy = (t_ff[0] == 8'h99);
            nxt_t[0] = cy ? 8'h00 : bcd_inc(t_ff[0]);
            if (cy) begin
                cy = (t_ff[1] == 8'h59);
                nxt_t[1] = cy ? 8'h00 : bcd_inc(t_ff[1]);
            end
            if (cy) begin
                cy = (t_ff[2] == 8'h59);
                nxt_t[2] = cy ? 8'h00 : bcd_inc(t_ff[2]);
            end
            if (cy) begin
                cy = (t_ff[3][5:0] == 6'h23);
                nxt_t[3][5:0] = cy ? 6'h00 : hr_inc[5:0];
                if (cy) begin
                    nxt_t[4][2:0] = (t_ff[4][2:0] == 3'h7) ? 3'h1 : t_ff[4][2:0] + 3'h1;
                end
            end
            if (cy) begin
                cy = (t_ff[5] == month_len(t_ff[6], t_ff[7]));
                nxt_t[5] = cy ? 8'h01 : bcd_inc(t_ff[5]);
            end
            if (cy) begin
                cy = (t_ff[6] == 8'h12);
                nxt_t[6] = cy ? 8'h01 : bcd_inc(t_ff[6]);
            end
            if (cy) begin
                cy = (t_ff[7] == 8'h99);
                nxt_t[7] = cy ? 8'h00 : bcd_inc(t_ff[7]);
                if (cy) begin
                    nxt_t[3][`SRC_BIT_CENTURY] = ~t_ff[3][`SRC_BIT_CENTURY];
                end
            end
        end
        // A bus write overrides the count in the same crystal edge
        if (xwr_tgl_s_ff != xwr_tgl_d_ff) begin
            nxt_t[wr_idx_ff] = wr_dat_ff;
        end
    end

    always_ff @(posedge i_xtal_clock) begin
        xrst_m_ff <= i_rst;
        xrst_ff <= xrst_m_ff;
        if (xrst_ff) begin
            xdiv_ff <= 9'h000;
            xtick_ff <= 1'b0;
            sq_cnt_ff <= 8'h00;
            sq_ff <= 1'b0;
            xwr_tgl_m_ff <= 1'b0;
            xwr_tgl_s_ff <= 1'b0;
            xwr_tgl_d_ff <= 1'b0;
            for (int i = 0; i < `SRC_TIME_REGS; i++) begin
                t_ff[i] <= (i >= 4 && i <= 6) ? 8'h01 : 8'h00;
            end
        end else begin
            xdiv_ff <= nxt_xdiv;
            xtick_ff <= nxt_xtick;
            sq_cnt_ff <= nxt_sq_cnt;
            sq_ff <= sq_cnt_ff[7];
            xwr_tgl_m_ff <= wr_tgl_ff;
            xwr_tgl_s_ff <= xwr_tgl_m_ff;
            xwr_tgl_d_ff <= xwr_tgl_s_ff;
            for (int i = 0; i < `SRC_TIME_REGS; i++) begin
                t_ff[i] <= nxt_t[i];
            end
        end
    end

    // System domain: pin synchronisers
    logic scl_m_ff, scl_s_ff, scl_d_ff, sda_m_ff, sda_s_ff, sda_d_ff;
    logic pf_m_ff, pf_s_ff, vf_m_ff, vf_s_ff, ce_m_ff, ce_s_ff, sq_m_ff, sq_s_ff;
    logic rsta_lvl, rstb_lvl;

    src_debounce u_deb_a (.i_clock(i_clock), .i_rst(i_rst),
        .i_raw(i_aux_reset_in_a_n), .o_level(rsta_lvl));
    src_debounce u_deb_b (.i_clock(i_clock), .i_rst(i_rst),
        .i_raw(i_aux_reset_in_b_n), .o_level(rstb_lvl));

    // User copy of the time, refreshed only when not frozen by a clock-range access.
    // Crystal-domain bytes are sampled twice and taken only when two reads agree.
    logic [7:0] cap_ff [0:`SRC_TIME_REGS-1];
    logic [7:0] usr_ff [0:`SRC_TIME_REGS-1];
    logic [7:0] mem_ff [`SRC_TIME_REGS:`SRC_SPACE_BYTES-1];
    logic frozen;

    src_state_t st_ff, nxt_st;
    logic [5:0] ptr_ff, nxt_ptr;
    logic [7:0] sh_ff, nxt_sh;
    logic [3:0] bit_ff, nxt_bit;
    logic rw_ff, nxt_rw, first_ff, nxt_first, oe_ff, nxt_oe;
    logic sess_ff, nxt_sess;
    logic mwe;
    logic [5:0] maddr;
    logic [7:0] mdat;

    wire scl_rise = scl_s_ff && !scl_d_ff;
    wire scl_fall = !scl_s_ff && scl_d_ff;
    wire start_c = scl_s_ff && scl_d_ff && sda_d_ff && !sda_s_ff;
    wire stop_c = scl_s_ff && scl_d_ff && !sda_d_ff && sda_s_ff;
    assign frozen = sess_ff && (ptr_ff <= `SRC_LAST_TIME_ADDR);

    function automatic logic [7:0] rd_byte(input logic [5:0] a);
        rd_byte = (a < 6'(`SRC_TIME_REGS - 12)) ? usr_ff[a[2:0]] : mem_ff[a];
    endfunction

    logic [7:0] rd_now;
    assign rd_now = rd_byte(ptr_ff);

    always_comb begin
        nxt_st = st_ff;
        nxt_ptr = ptr_ff;
        nxt_sh = sh_ff;
        nxt_bit = bit_ff;
        nxt_rw = rw_ff;
        nxt_first = first_ff;
        nxt_oe = oe_ff;
        nxt_sess = sess_ff;
        nxt_wr_tgl = wr_tgl_ff;
        nxt_wr_idx = wr_idx_ff;
        nxt_wr_dat = wr_dat_ff;
        mwe = 1'b0;
        maddr = ptr_ff;
        mdat = sh_ff;
        if (vf_s_ff) begin
            nxt_st = SRC_DROP;
            nxt_ptr = 6'h00;
            nxt_oe = 1'b0;
            nxt_sess = 1'b0;
        end else if (stop_c) begin
            nxt_st = SRC_IDLE;
            nxt_oe = 1'b0;
            nxt_sess = 1'b0;
        end else if (start_c) begin
            nxt_st = SRC_ADDR;
            nxt_bit = 4'h0;
            nxt_oe = 1'b0;
        end else begin
            case (st_ff)
                SRC_ADDR, SRC_RX: begin
                    if (scl_rise) begin
                        nxt_sh = {sh_ff[6:0], sda_s_ff};
                        nxt_bit = bit_ff + 4'h1;
                    end else if (scl_fall && bit_ff == 4'h8) begin
                        if (st_ff == SRC_ADDR) begin
                            if (sh_ff[7:1] == `SRC_SLAVE_ADDR) begin
                                nxt_rw = sh_ff[0];
                                nxt_first = 1'b1;
                                nxt_sess = 1'b1;
                                nxt_oe = 1'b1;
                                nxt_st = SRC_ADDR_ACK;
                            end else begin
                                nxt_st = SRC_DROP;
                            end
                        end else begin
                            nxt_oe = 1'b1;
                            nxt_st = SRC_RX_ACK;
                        end
                    end
                end
                SRC_ADDR_ACK, SRC_RX_ACK: begin
                    if (scl_fall) begin
                        nxt_oe = 1'b0;
                        nxt_bit = 4'h0;
                        if (st_ff == SRC_RX_ACK) begin
                            if (first_ff) begin
                                nxt_ptr = sh_ff[5:0];
                                nxt_first = 1'b0;
                            end else begin
                                mwe = 1'b1;
                                nxt_ptr = ptr_ff + 6'h01;
                            end
                            nxt_st = SRC_RX;
                        end else if (rw_ff) begin
                            nxt_sh = rd_now;
                            nxt_oe = !rd_now[7];
                            nxt_st = SRC_TX;
                        end else begin
                            nxt_st = SRC_RX;
                        end
                    end
                end
                SRC_TX: begin
                    if (scl_fall) begin
                        nxt_bit = bit_ff + 4'h1;
                        nxt_sh = {sh_ff[6:0], 1'b1};
                        nxt_oe = (bit_ff != 4'h7) && !sh_ff[6];
                        if (bit_ff == 4'h7) begin
                            nxt_st = SRC_TX_ACK;
                        end
                    end
                end
                SRC_TX_ACK: begin
                    if (scl_rise) begin
                        nxt_ptr = ptr_ff + 6'h01;
                        nxt_st = sda_s_ff ? SRC_DROP : SRC_ADDR_ACK;
                    end
                end
                default: nxt_oe = 1'b0;
            endcase
        end
        if (mwe && ptr_ff <= `SRC_LAST_TIME_ADDR) begin
            nxt_wr_idx = ptr_ff[2:0];
            nxt_wr_dat = sh_ff;
            nxt_wr_tgl = ~wr_tgl_ff;
        end
    end

    always_ff @(posedge i_clock) begin
        scl_m_ff <= i_scl;
        scl_s_ff <= scl_m_ff;
        scl_d_ff <= scl_s_ff;
        sda_m_ff <= i_sda;
        sda_s_ff <= sda_m_ff;
        sda_d_ff <= sda_s_ff;
        pf_m_ff <= i_powerfail_sense_in;
        pf_s_ff <= pf_m_ff;
        vf_m_ff <= i_vcc_fail;
        vf_s_ff <= vf_m_ff;
        ce_m_ff <= i_sram_enable_in_n;
        ce_s_ff <= ce_m_ff;
        sq_m_ff <= sq_ff;
        sq_s_ff <= sq_m_ff;
        for (int i = 0; i < `SRC_TIME_REGS; i++) begin
            cap_ff[i] <= t_ff[i];
            if (!frozen && cap_ff[i] == t_ff[i]) begin
                usr_ff[i] <= cap_ff[i];
            end
        end
        if (mwe && ptr_ff > `SRC_LAST_TIME_ADDR) begin
            mem_ff[maddr] <= mdat;
        end
        if (i_rst) begin
            st_ff <= SRC_IDLE;
            ptr_ff <= 6'h00;
            sh_ff <= 8'h00;
            bit_ff <= 4'h0;
            rw_ff <= 1'b0;
            first_ff <= 1'b0;
            oe_ff <= 1'b0;
            sess_ff <= 1'b0;
            wr_tgl_ff <= 1'b0;
            wr_idx_ff <= 3'h0;
            wr_dat_ff <= 8'h00;
            o_sda_oe <= 1'b0;
            o_gated_sram_enable_out_n <= 1'b1;
            o_powerfail_warn_out_n <= 1'b1;
            o_reset_oe <= 1'b1;
            o_irq_test_out_pin_oe <= 1'b0;
            o_square_wave_out <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            ptr_ff <= nxt_ptr;
            sh_ff <= nxt_sh;
            bit_ff <= nxt_bit;
            rw_ff <= nxt_rw;
            first_ff <= nxt_first;
            oe_ff <= nxt_oe;
            sess_ff <= nxt_sess;
            wr_tgl_ff <= nxt_wr_tgl;
            wr_idx_ff <= nxt_wr_idx;
            wr_dat_ff <= nxt_wr_dat;
            o_sda_oe <= nxt_oe;
            o_gated_sram_enable_out_n <= vf_s_ff ? 1'b1 : ce_s_ff;
            o_powerfail_warn_out_n <= !pf_s_ff;
            o_reset_oe <= vf_s_ff || !rsta_lvl || !rstb_lvl;
            // Open drain: enable held at zero, so the pin is always released
            o_irq_test_out_pin_oe <= 1'b0;
            o_square_wave_out <= sq_s_ff;
        end
    end

    assign o_sda_out = 1'b0;
    assign o_reset_out = 1'b0;
    assign o_irq_test_out_pin_out = 1'b0;
endmodule
`default_nettype wire

// File: dv/src_i2c_master.sv
// Behavioural two-wire bus master driving the core's slave port
`timescale 1ns/1ns
`default_nettype none
module src_i2c_master (
    input wire logic i_clock,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic half();
        repeat (20) @(negedge i_clock);
    endtask
    // Also serves as repeated start: data rises with clock low first
    task automatic start();
        o_sda = 1'b1;
        half();
        o_scl = 1'b1;
        half();
        o_sda = 1'b0;
        half();
        o_scl = 1'b0;
        half();
    endtask
    task automatic stop();
        o_sda = 1'b0;
        half();
        o_scl = 1'b1;
        half();
        o_sda = 1'b1;
        half();
    endtask
    // Eight bits MSB first plus acknowledge; a 1 releases the line to the pull-up
    task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                        output logic ack);
        logic [8:0] w;
        w = {d, ack_in};
        for (int i = 8; i >= 0; i--) begin
            o_sda = w[i];
            half();
            o_scl = 1'b1;
            repeat (10) @(negedge i_clock);
            w[i] = i_sda;
            repeat (10) @(negedge i_clock);
            o_scl = 1'b0;
        end
        q = w[8:1];
        ack = w[0];
    endtask
endmodule
`default_nettype wire

// File: dv/src_rtc_core_monitor.sv
// Port checker for the serial clock/calendar core
`timescale 1ns/1ns
`default_nettype none
module src_rtc_core_monitor
    import src_pkg::*;
#(
    parameter logic [8:0] TICKS_PER_HUND = 9'h148
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_xtal_clock,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda_oe,
    input wire logic o_sda_out,
    input wire logic i_sram_enable_in_n,
    input wire logic o_gated_sram_enable_out_n,
    input wire logic i_powerfail_sense_in,
    input wire logic o_powerfail_warn_out_n,
    input wire logic i_vcc_fail,
    input wire logic i_aux_reset_in_a_n,
    input wire logic i_aux_reset_in_b_n,
    input wire logic o_reset_oe,
    input wire logic o_reset_out,
    input wire logic o_irq_test_out_pin_oe,
    input wire logic o_irq_test_out_pin_out,
    input wire logic o_square_wave_out
);
    logic [10:0] low_cnt_ff;
    logic [10:0] nxt_low_cnt;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // Saturates so a long-held request never wraps back under the debounce bound
    always_comb begin
        nxt_low_cnt = 11'h000;
        if (!i_aux_reset_in_a_n || !i_aux_reset_in_b_n) begin
            nxt_low_cnt = (low_cnt_ff == 11'h7FF) ? low_cnt_ff : low_cnt_ff + 11'h001;
        end
    end
    always_ff @(posedge i_clock) begin
        low_cnt_ff <= i_rst ? 11'h000 : nxt_low_cnt;
    end
    AST_SDA_OUT_LOW: assert property (!o_sda_out)
        else $error("data pin driven high");
    AST_IRQ_PIN_LOW_ONLY: assert property (!o_irq_test_out_pin_out)
        else $error("irq pin driven high");
    AST_RESET_PIN_LOW_ONLY: assert property (!o_reset_out)
        else $error("reset pin driven high");
    AST_CE_BLOCKED: assert property (i_vcc_fail [*5] |-> o_gated_sram_enable_out_n)
        else $error("sram enable not blocked in power fail");
    AST_CE_PASS: assert property ((!i_vcc_fail && $stable(i_sram_enable_in_n)) [*5]
        |-> o_gated_sram_enable_out_n == i_sram_enable_in_n) else $error("sram enable not passed");
    AST_BUS_IGNORED: assert property (i_vcc_fail [*5] |-> !o_sda_oe)
        else $error("bus driven during supply fail");
    AST_SDA_CHANGE_LOW: assert property ($rose(o_sda_oe) |-> !i_scl && !$past(i_scl))
        else $error("data pulled while clock high");
    AST_SDA_STABLE_HIGH: assert property ((i_scl && !i_vcc_fail) [*6] |-> $stable(o_sda_oe))
        else $error("data changed while clock high");
    AST_AUX_RESET: assert property (low_cnt_ff > 11'h410 |-> o_reset_oe)
        else $error("aux reset request not forwarded");
    AST_WARN: assert property (i_powerfail_sense_in [*5] |-> !o_powerfail_warn_out_n)
        else $error("power fail warning missing");
endmodule
bind src_rtc_core src_rtc_core_monitor #(.TICKS_PER_HUND(TICKS_PER_HUND)) u_mon (
    .i_clock(i_clock), .i_rst(i_rst), .i_xtal_clock(i_xtal_clock), .i_scl(i_scl),
    .i_sda(i_sda), .o_sda_oe(o_sda_oe), .o_sda_out(o_sda_out),
    .i_sram_enable_in_n(i_sram_enable_in_n),
    .o_gated_sram_enable_out_n(o_gated_sram_enable_out_n),
    .i_powerfail_sense_in(i_powerfail_sense_in), .o_powerfail_warn_out_n(o_powerfail_warn_out_n),
    .i_vcc_fail(i_vcc_fail), .i_aux_reset_in_a_n(i_aux_reset_in_a_n),
    .i_aux_reset_in_b_n(i_aux_reset_in_b_n), .o_reset_oe(o_reset_oe), .o_reset_out(o_reset_out),
    .o_irq_test_out_pin_oe(o_irq_test_out_pin_oe), .o_irq_test_out_pin_out(o_irq_test_out_pin_out),
    .o_square_wave_out(o_square_wave_out));
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the serial clock/calendar core
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; \
    $display("[ERR] %0t got %h want %h", $time, (got), (exp)); end end
module tb;
    logic i_clock, i_rst, xclk, scl, sda_m, sda, ce_n, vcc, powerfail_sense_in, ra_n, rb_n, ak;
    logic sda_oe, sda_out, ce_out_n, warn_n, rst_oe, rst_out, irq_oe, irq_out, square_wave_out;
    logic [7:0] q;
    logic [7:0] r [$];
    int mismatches = 0;
    int samples_checked = 0;
    // Rows: date, month, year before midnight, then date, month, year after it
    logic [47:0] cal [5] = '{48'h28_02_23_01_03_23, 48'h28_02_24_29_02_24, 48'h28_02_12_29_02_12,
                             48'h30_04_23_01_05_23, 48'h31_12_99_01_01_00};
    assign sda = sda_m & (sda_oe ? sda_out : 1'b1);
    always #2 i_clock = ~i_clock;
    initial begin
        xclk = 1'b0;
        #7;
        forever #80 xclk = ~xclk;
    end
    src_rtc_core #(.TICKS_PER_HUND(9'h002)) uut (
        .i_clock(i_clock), .i_rst(i_rst), .i_xtal_clock(xclk), .i_scl(scl), .i_sda(sda),
        .o_sda_oe(sda_oe), .o_sda_out(sda_out), .i_sram_enable_in_n(ce_n),
        .o_gated_sram_enable_out_n(ce_out_n), .i_powerfail_sense_in(powerfail_sense_in),
        .o_powerfail_warn_out_n(warn_n), .i_vcc_fail(vcc), .i_aux_reset_in_a_n(ra_n),
        .i_aux_reset_in_b_n(rb_n), .o_reset_oe(rst_oe), .o_reset_out(rst_out),
        .o_irq_test_out_pin_oe(irq_oe), .o_irq_test_out_pin_out(irq_out),
        .o_square_wave_out(square_wave_out));
    src_i2c_master m (.i_clock(i_clock), .i_sda(sda), .o_scl(scl), .o_sda(sda_m));
    task automatic finish_test();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d [$]);
        m.start();
        m.xfer(8'hD0, 1'b1, q, ak);
        `CHK(ak, 1'b0)
        m.xfer({2'b00, a}, 1'b1, q, ak);
        `CHK(ak, 1'b0)
        foreach (d[i]) begin
            m.xfer(d[i], 1'b1, q, ak);
            `CHK(ak, 1'b0)
        end
        m.stop();
    endtask
    // Sets the pointer, repeats start, reads n bytes and refuses the last
    task automatic rd(input logic [5:0] a, input int n);
        r.delete();
        m.start();
        m.xfer(8'hD0, 1'b1, q, ak);
        m.xfer({2'b00, a}, 1'b1, q, ak);
        m.start();
        m.xfer(8'hD1, 1'b1, q, ak);
        `CHK(ak, 1'b0)
        for (int i = 0; i < n; i++) begin
            m.xfer(8'hFF, i == n - 1, q, ak);
            r.push_back(q);
        end
        m.stop();
    endtask
    task automatic sup(input logic v, input logic c, input logic p, input logic ec,
                       input logic ew);
        vcc = v;
        ce_n = c;
        powerfail_sense_in = p;
        repeat (6) @(negedge i_clock);
        `CHK(ce_out_n, ec)
        `CHK(warn_n, ew)
    endtask
    initial begin
        repeat (100000) @(posedge i_clock);
        mismatches++;
        finish_test();
    end
    initial begin
        i_clock = 1'b0;
        i_rst = 1'b1;
        ce_n = 1'b1;
        vcc = 1'b0;
        powerfail_sense_in = 1'b0;
        ra_n = 1'b1;
        rb_n = 1'b1;
        // Held past three crystal edges so the slow domain sees the reset too
        repeat (5) @(negedge i_clock);
        repeat (3) @(posedge xclk);
        @(negedge i_clock);
        `CHK(sda_oe, 1'b0)
        `CHK(rst_oe, 1'b1)
        `CHK(ce_out_n, 1'b1)
        `CHK(irq_oe, 1'b0)
        i_rst = 1'b0;
        repeat (1100) @(negedge i_clock);
        `CHK(rst_oe, 1'b0)
        // Hundredths start at zero so the midnight carry lands well after the write
        foreach (cal[i]) begin
            wr(6'h00, '{8'h00, 8'h59, 8'h59, 8'h23, 8'h01, cal[i][47:40], cal[i][39:32],
                        cal[i][31:24]});
            repeat (7000) @(negedge i_clock);
            rd(6'h01, 7);
            `CHK(r[0], 8'h00)
            `CHK(r[1], 8'h00)
            `CHK(r[2][5:0], 6'h00)
            `CHK(r[3], 8'h02)
            `CHK(r[4], cal[i][23:16])
            `CHK(r[5], cal[i][15:8])
            `CHK(r[6], cal[i][7:0])
        end
        // Square wave flips every 128 crystal edges; same sampling offset both times
        @(posedge xclk);
        repeat (8) @(negedge i_clock);
        ak = square_wave_out;
        repeat (128) @(posedge xclk);
        repeat (8) @(negedge i_clock);
        `CHK(square_wave_out, !ak)
        wr(6'h3D, '{8'hA5, 8'h5A, 8'hC3});
        rd(6'h3D, 3);
        `CHK(r[0], 8'hA5)
        `CHK(r[1], 8'h5A)
        `CHK(r[2], 8'hC3)
        m.start();
        m.xfer(8'hA0, 1'b1, q, ak);
        `CHK(ak, 1'b1)
        m.stop();
        m.start();
        m.xfer(8'hD0, 1'b1, q, ak);
        vcc = 1'b1;
        m.xfer(8'h14, 1'b1, q, ak);
        `CHK(ak, 1'b1)
        vcc = 1'b0;
        m.stop();
        sup(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        sup(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        sup(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
        sup(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        for (int k = 0; k < 2; k++) begin
            ra_n = (k != 0);
            rb_n = (k == 0);
            repeat (1100) @(negedge i_clock);
            `CHK(rst_oe, 1'b1)
            ra_n = 1'b1;
            rb_n = 1'b1;
            repeat (1100) @(negedge i_clock);
            `CHK(rst_oe, 1'b0)
        end
        finish_test();
    end
endmodule
`default_nettype wire
